/* src/lcd_gpio_ports.sv */
// two gpio ports sharing pins with lcd common and segment outputs
//
// Contract
// RULE1: direction one makes the pin an output
// RULE2: direction zero makes an input, driver off
// RULE3: output pin drives the latch level
// RULE4: data writes always update the latch
// RULE5: output pin reads return the latch
// RULE6: input reads pin, rmw read returns latch
// RULE7: reset clears all direction bits
// RULE8: float bit in standby: hi-z, input low
// RULE9: float bit clear: standby keeps pin state
// RULE10: common-select bit picks lcd or port
// RULE11: segment-select bits pick lcd or port
// RULE12: software sets select before input control
// RULE13: software clears direction on lcd pins
// RULE14: software disables other sharing peripherals
// RULE15: port a bits map to own pins
// RULE16: port b only bits 4..0 have pins
// RULE17: port b upper bits read zero
// RULE18: armed lcd select overrides port driver
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module lcd_gpio_ports
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // register port
  input wire logic [lcd_gpio_pkg::ADDR_W-1:0] addr_i,
  input wire logic [lcd_gpio_pkg::REG_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic rmw_i,
  output logic [lcd_gpio_pkg::REG_W-1:0] rdata_o,
  // standby state from the standby controller
  input wire logic stop_mode_i,
  input wire logic watch_mode_i,
  // lcd controller drive levels
  input wire logic [lcd_gpio_pkg::PORT_A_W-1:0] lcd_com_i,
  input wire logic [lcd_gpio_pkg::SEG_LOW_W-1:0] lcd_seg_low_i,
  input wire logic [lcd_gpio_pkg::SEG_HIGH_W-1:0] lcd_seg_high_i,
  // port a pins
  input wire logic [lcd_gpio_pkg::PORT_A_W-1:0] pa_in_i,
  output logic [lcd_gpio_pkg::PORT_A_W-1:0] pa_out_o,
  output logic [lcd_gpio_pkg::PORT_A_W-1:0] pa_oe_o,
  // port b pins
  input wire logic [lcd_gpio_pkg::PORT_B_W-1:0] pb_in_i,
  output logic [lcd_gpio_pkg::PORT_B_W-1:0] pb_out_o,
  output logic [lcd_gpio_pkg::PORT_B_W-1:0] pb_oe_o
);
  import lcd_gpio_pkg::*;

  logic [PORT_A_W-1:0] latch_a;
  logic [PORT_A_W-1:0] dir_a;
  logic [PORT_A_W-1:0] in_a;
  logic [PORT_B_W-1:0] latch_b;
  logic [PORT_B_W-1:0] dir_b;
  logic [PORT_B_W-1:0] in_b;
  logic [PORT_A_W-1:0] com_sel_r;
  logic [SEG_LOW_W-1:0] seg_low_r;
  logic [SEG_HIGH_W-1:0] seg_high_r;
  logic [PORT_B_W-1:0] seg_sel_b;
  logic [PORT_B_W-1:0] seg_val_b;
  logic lcd_port_input_control_r;
  logic standby_pin_float_r;
  logic float_w;
  logic [REG_W-1:0] rdata_nxt;
  logic [REG_W-1:0] rd_b_full;

  // port b bit order: seg 1:0 on bits 1:0, lcd_segment_select_high_bits on bits 4:2
  assign seg_sel_b = {seg_high_r, seg_low_r}; // RULE11
  assign seg_val_b = {lcd_seg_high_i, lcd_seg_low_i};

  // float only while a stop or watch mode is actually in force
  assign float_w = standby_pin_float_r & (stop_mode_i | watch_mode_i); // RULE8 RULE9

  // port a registers
  gpio_port_regs #(.W(PORT_A_W)) regs_a
  (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .data_we_i(wr_i && addr_i == OFF_A_DATA),
    .dir_we_i(wr_i && addr_i == OFF_A_DIR),
    .wdata_i(wdata_i),
    .latch_o(latch_a),
    .dir_o(dir_a)
  );

  // port b registers; bits 7:5 are dropped on write
  gpio_port_regs #(.W(PORT_B_W)) regs_b
  (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .data_we_i(wr_i && addr_i == OFF_B_DATA),
    .dir_we_i(wr_i && addr_i == OFF_B_DIR),
    .wdata_i(wdata_i),
    .latch_o(latch_b),
    .dir_o(dir_b)
  ); // RULE17

  // port a pin logic, shared with lcd commons
  gpio_pin_cell #(.W(PORT_A_W)) pins_a
  (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .latch_i(latch_a),
    .dir_i(dir_a),
    .lcd_sel_i(com_sel_r),
    .lcd_val_i(lcd_com_i),
    .lcd_port_input_control_i(lcd_port_input_control_r),
    .float_i(float_w),
    .pin_in_i(pa_in_i),
    .pin_out_o(pa_out_o),
    .pin_oe_o(pa_oe_o),
    .in_o(in_a)
  );

  // port b pin logic, shared with lcd segments
  gpio_pin_cell #(.W(PORT_B_W)) pins_b
  (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .latch_i(latch_b),
    .dir_i(dir_b),
    .lcd_sel_i(seg_sel_b),
    .lcd_val_i(seg_val_b),
    .lcd_port_input_control_i(lcd_port_input_control_r),
    .float_i(float_w),
    .pin_in_i(pb_in_i),
    .pin_out_o(pb_out_o),
    .pin_oe_o(pb_oe_o),
    .in_o(in_b)
  );

  // lcd routing registers
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      com_sel_r <= LCD_SEL_RST;
      seg_low_r <= LCD_SEL_RST[SEG_LOW_W-1:0];
      seg_high_r <= LCD_SEL_RST[SEG_HIGH_W-1:0];
      lcd_port_input_control_r <= 1'b0;
    end
    else if (wr_i)
    begin
      if (addr_i == OFF_LCD_COM_SEL)
        com_sel_r <= wdata_i; // RULE10
      if (addr_i == OFF_LCD_SEG_LOW)
        seg_low_r <= wdata_i[SEG_LOW_W-1:0];
      if (addr_i == OFF_LCD_SEG_HIGH)
        seg_high_r <= wdata_i[SEG_HIGH_W-1:0];
      if (addr_i == OFF_LCD_PIN_EN)
        lcd_port_input_control_r <= wdata_i[LCD_PORT_INPUT_CONTROL_BIT]; // RULE12
    end
  end

  // standby float control
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      standby_pin_float_r <= 1'b0;
    else if (wr_i && addr_i == OFF_STANDBY_CTL)
      standby_pin_float_r <= wdata_i[STANDBY_PIN_FLOAT_BIT];
  end

  // port b read value, upper bits forced to zero
  assign rd_b_full = port_read_value({3'h0, latch_b}, {3'h0, dir_b}, {3'h0, in_b}, rmw_i);

  // read data select
  always_comb
  begin
    rdata_nxt = UNMAPPED_VAL;
    unique case (addr_i)
      OFF_A_DATA: rdata_nxt = port_read_value(latch_a, dir_a, in_a, rmw_i); // RULE5 RULE6
      OFF_A_DIR: rdata_nxt = dir_a;
      OFF_B_DATA: rdata_nxt = {3'h0, rd_b_full[PORT_B_W-1:0]}; // RULE16 RULE17
      OFF_B_DIR: rdata_nxt = {3'h0, dir_b};
      OFF_LCD_PIN_EN: rdata_nxt = {7'h00, lcd_port_input_control_r};
      OFF_LCD_COM_SEL: rdata_nxt = com_sel_r;
      OFF_LCD_SEG_LOW: rdata_nxt = {6'h00, seg_low_r};
      OFF_LCD_SEG_HIGH: rdata_nxt = {5'h00, seg_high_r};
      OFF_STANDBY_CTL: rdata_nxt = {7'h00, standby_pin_float_r};
      default: rdata_nxt = UNMAPPED_VAL;
    endcase
  end

  // read data valid the cycle after the strobe only
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      rdata_o <= '0;
    else if (rd_i)
      rdata_o <= rdata_nxt;
    else
      rdata_o <= '0;
  end

  // reset leaves every pin an input
  AST_DIR_RESET: assert property (@(posedge clk_sys_i) // RULE7
    srst_i |=> (dir_a == '0 && dir_b == '0))
    else $error("direction not cleared by reset");

  // a data write lands in the latch whatever the direction
  AST_LATCH_WRITE: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE4
    (wr_i && addr_i == OFF_A_DATA) |=> latch_a == $past(wdata_i))
    else $error("port a latch missed a write");

  // driver enable follows direction or lcd ownership when not floated
  AST_A_ENABLE: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE1
    !float_w |=> pa_oe_o == $past((com_sel_r & {8{lcd_port_input_control_r}}) | dir_a))
    else $error("port a driver enable wrong");

  // output level is latch or lcd value, bit by bit
  AST_A_LEVEL: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE3
    1'b1 |=> pa_out_o == $past(((com_sel_r & {8{lcd_port_input_control_r}}) & lcd_com_i)
      | (~(com_sel_r & {8{lcd_port_input_control_r}}) & latch_a)))
    else $error("port a output level wrong");

  // segment pins take the lcd level once armed, checked per selected bit
  AST_B_LCD: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE18
    (lcd_port_input_control_r && !float_w) |=> ((pb_oe_o & $past(seg_sel_b))
      == $past(seg_sel_b) && (pb_out_o & $past(seg_sel_b)) == $past(seg_sel_b & seg_val_b)))
    else $error("port b lcd override failed");

  // floated pins are released and read low, held for two cycles
  AST_FLOAT: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE8
    float_w [*2] |=> (pa_oe_o == '0 && pb_oe_o == '0 && in_a == '0 && in_b == '0))
    else $error("standby float not applied");

  // standby without float keeps the drive pattern
  AST_KEEP: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE9
    (!standby_pin_float_r && (stop_mode_i || watch_mode_i)) |=> pb_oe_o == $past(
      (seg_sel_b & {5{lcd_port_input_control_r}}) | dir_b))
    else $error("standby changed pin drive");

  // output pins read back the latch
  AST_RD_OUT: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE5
    (rd_i && addr_i == OFF_A_DATA && dir_a == 8'hFF) |=> rdata_o == $past(latch_a))
    else $error("output read not from latch");

  // input pins read the pin unless the read is read-modify-write
  AST_RD_IN: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE6
    (rd_i && addr_i == OFF_A_DATA && dir_a == 8'h00) |=>
      rdata_o == ($past(rmw_i) ? $past(latch_a) : $past(in_a)))
    else $error("input read source wrong");

  // port b upper bits always read zero
  AST_B_UPPER: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE17
    (rd_i && (addr_i == OFF_B_DATA || addr_i == OFF_B_DIR)) |=> rdata_o[7:5] == 3'h0)
    else $error("port b upper bits not zero");

  // read data appears for one cycle only
  AST_RD_ONE: assert property (@(posedge clk_sys_i) disable iff (srst_i) // strobed register port, chosen here
    !rd_i |=> rdata_o == '0)
    else $error("read data outside its cycle");

  // port b driver enable follows direction or lcd ownership
  AST_B_ENABLE: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE2
    !float_w |=> pb_oe_o == $past((seg_sel_b & {5{lcd_port_input_control_r}}) | dir_b))
    else $error("port b driver enable wrong");

  // port b level is latch or segment value, bit by bit
  AST_B_LEVEL: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE3
    1'b1 |=> pb_out_o == $past(((seg_sel_b & {5{lcd_port_input_control_r}}) & seg_val_b)
      | (~(seg_sel_b & {5{lcd_port_input_control_r}}) & latch_b)))
    else $error("port b output level wrong");

  // port b latch keeps only the bits that have pins
  AST_B_LATCH_WRITE: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE4
    (wr_i && addr_i == OFF_B_DATA) |=> latch_b == $past(wdata_i[PORT_B_W-1:0]))
    else $error("port b latch missed a write");

  // a direction write lands as written
  AST_DIR_WRITE: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE1
    (wr_i && addr_i == OFF_A_DIR) |=> dir_a == $past(wdata_i))
    else $error("port a direction missed a write");

  // common pins owned by the lcd drive the lcd level
  AST_A_LCD: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE10
    (lcd_port_input_control_r && !float_w) |=> ((pa_oe_o & $past(com_sel_r))
      == $past(com_sel_r) && (pa_out_o & $past(com_sel_r)) == $past(com_sel_r & lcd_com_i)))
    else $error("port a lcd override failed");

  // port a input register follows the pins the lcd does not own
  AST_A_INPUT: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE15
    (lcd_port_input_control_r && !float_w) |=> in_a == $past(pa_in_i & ~com_sel_r))
    else $error("port a input sample wrong");

  // input path stays low until routing is armed, so no open pin leaks in
  AST_IN_GATED: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE6
    !lcd_port_input_control_r |=> (in_a == '0 && in_b == '0))
    else $error("input path open without input control");

  // port b output pins read back the latch
  AST_B_RD_OUT: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE5
    (rd_i && addr_i == OFF_B_DATA && dir_b == 5'h1F) |=> rdata_o == {3'h0, $past(latch_b)})
    else $error("port b output read not from latch");

  // a read-modify-write read of port b returns the latch
  AST_B_RMW: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE6
    (rd_i && rmw_i && addr_i == OFF_B_DATA) |=> rdata_o == {3'h0, $past(latch_b)})
    else $error("port b read-modify-write read wrong");

endmodule : lcd_gpio_ports

/* inc/lcd_gpio_pkg.sv */
// constants, offsets and shared helpers for the lcd-shared gpio ports
package lcd_gpio_pkg;

  // port widths
  localparam int PORT_A_W = 8;
  localparam int PORT_B_W = 5;
  localparam int REG_W = 8;
  localparam int ADDR_W = 8;

  // register offsets
  localparam logic [7:0] OFF_A_DATA = 8'h00;
  localparam logic [7:0] OFF_A_DIR = 8'h01;
  localparam logic [7:0] OFF_B_DATA = 8'h02;
  localparam logic [7:0] OFF_B_DIR = 8'h03;
  localparam logic [7:0] OFF_LCD_PIN_EN = 8'h04;
  localparam logic [7:0] OFF_LCD_COM_SEL = 8'h05;
  localparam logic [7:0] OFF_LCD_SEG_LOW = 8'h06;
  localparam logic [7:0] OFF_LCD_SEG_HIGH = 8'h07;
  localparam logic [7:0] OFF_STANDBY_CTL = 8'h08;

  // field positions and widths
  localparam int LCD_PORT_INPUT_CONTROL_BIT = 0;
  localparam int STANDBY_PIN_FLOAT_BIT = 0;
  localparam int SEG_LOW_W = 2;
  localparam int SEG_HIGH_W = 3;

  // reset values and the unmapped read value
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] LCD_SEL_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_VAL = 8'h00;

  // per-bit read value: latch for outputs or rmw reads, pin otherwise
  function automatic logic [7:0] port_read_value(
    input logic [7:0] latch,
    input logic [7:0] dir,
    input logic [7:0] pin,
    input logic read_modify_write_access
  );
    logic [7:0] sel;
    sel = dir | {8{read_modify_write_access}};
    port_read_value = (sel & latch) | (~sel & pin);
  endfunction : port_read_value

endpackage : lcd_gpio_pkg

/* src/gpio_port_regs.sv */
// data latch and direction register for one port
`timescale 1ns/1ns
module gpio_port_regs
#(
  parameter int W = 8
)
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // write side
  input wire logic data_we_i,
  input wire logic dir_we_i,
  input wire logic [lcd_gpio_pkg::REG_W-1:0] wdata_i,
  // register contents
  output logic [W-1:0] latch_o,
  output logic [W-1:0] dir_o
);
  import lcd_gpio_pkg::*;

  // output latch takes every write, whatever the direction
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      latch_o <= LATCH_RST[W-1:0];
    else if (data_we_i)
      latch_o <= wdata_i[W-1:0]; // RULE4
  end

  // direction clears on reset so every pin starts as input
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      dir_o <= DIR_RST[W-1:0]; // RULE7
    else if (dir_we_i)
      dir_o <= wdata_i[W-1:0];
  end

endmodule : gpio_port_regs

/* src/gpio_pin_cell.sv */
// pin drive, lcd override, standby float and input gating for one port
`timescale 1ns/1ns
module gpio_pin_cell
#(
  parameter int W = 8
)
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // port state
  input wire logic [W-1:0] latch_i,
  input wire logic [W-1:0] dir_i,
  // lcd routing
  input wire logic [W-1:0] lcd_sel_i,
  input wire logic [W-1:0] lcd_val_i,
  input wire logic lcd_port_input_control_i,
  // standby
  input wire logic float_i,
  // pin
  input wire logic [W-1:0] pin_in_i,
  output logic [W-1:0] pin_out_o,
  output logic [W-1:0] pin_oe_o,
  output logic [W-1:0] in_o
);
  logic [W-1:0] lcd_own;

  // lcd owns a pin only once routing is armed
  assign lcd_own = lcd_sel_i & {W{lcd_port_input_control_i}}; // RULE10 RULE11

  // output level: lcd value where it owns the pin, else the latch
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      pin_out_o <= '0;
    else
      pin_out_o <= (lcd_own & lcd_val_i) | (~lcd_own & latch_i); // RULE3 RULE18 RULE15
  end

  // driver enable; standby float overrides everything
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      pin_oe_o <= '0;
    else if (float_i)
      pin_oe_o <= '0; // RULE8
    else
      pin_oe_o <= lcd_own | (~lcd_own & dir_i); // RULE1 RULE2 RULE9
  end

  // input path held low while floated or routing not yet armed,
  // so an open pin never leaks into the read data
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      in_o <= '0;
    else if (float_i || !lcd_port_input_control_i)
      in_o <= '0; // RULE8
    else
      in_o <= pin_in_i & ~lcd_own;
  end

endmodule : gpio_pin_cell

/* bench/pin_wire_model.sv */
// model of the board wiring and outside drivers on one port's pins
`timescale 1ns/1ns
module pin_wire_model
#(
  parameter int W = 8
)
(
  // device side of each pin
  input wire logic [W-1:0] out_i,
  input wire logic [W-1:0] oe_i,
  // level the outside world drives when the device lets go
  input wire logic [W-1:0] ext_i,
  // resolved pin level back to the device
  output logic [W-1:0] pin_o
);
  // outside drivers yield while the device drives, so no fight on the wire
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      pin_o[i] = oe_i[i] ? out_i[i] : ext_i[i];
    end
  end
endmodule : pin_wire_model

/* bench/lcd_gpio_ports_test.sv */
// self-checking bench for the lcd-shared gpio ports
`timescale 1ns/1ns
module lcd_gpio_ports_test;
  import lcd_gpio_pkg::*;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic wr_i = 1'b0, rd_i = 1'b0, rmw_i = 1'b0, stop_mode_i = 1'b0, watch_mode_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, lcd_com_i = 8'h00, ext_a = 8'h00;
  logic [7:0] pa_in_i, pa_out_o, pa_oe_o, rdata_o;
  logic [1:0] lcd_seg_low_i = 2'h0;
  logic [2:0] lcd_seg_high_i = 3'h0;
  logic [4:0] ext_b = 5'h00, pb_in_i, pb_out_o, pb_oe_o;
  // shadow copies of what software wrote
  logic [7:0] la, da, lb, db, sa, sb;
  int errors = 0, checks = 0, seed;

  always #50 clk_sys_i = ~clk_sys_i;

  lcd_gpio_ports dut_u (.clk_sys_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rmw_i,
    .rdata_o, .stop_mode_i, .watch_mode_i, .lcd_com_i, .lcd_seg_low_i, .lcd_seg_high_i,
    .pa_in_i, .pa_out_o, .pa_oe_o, .pb_in_i, .pb_out_o, .pb_oe_o);
  pin_wire_model #(.W(8)) wire_a_u (.out_i(pa_out_o), .oe_i(pa_oe_o), .ext_i(ext_a),
    .pin_o(pa_in_i));
  pin_wire_model #(.W(5)) wire_b_u (.out_i(pb_out_o), .oe_i(pb_oe_o), .ext_i(ext_b),
    .pin_o(pb_in_i));

  task automatic stop_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : idle

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr

  // read data is only valid in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] e, input string n);
    @(posedge clk_sys_i);
    addr_i <= a;
    rmw_i <= m;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    cmp(n, e, rdata_o);
    // hand back on a rising edge so callers drive inputs there
    @(posedge clk_sys_i);
  endtask : rd

  // latch for outputs or rmw reads, pin level otherwise
  function automatic logic [7:0] exp_rd(input logic [7:0] l, d, p, input logic m);
    return ((d | {8{m}}) & l) | (~(d | {8{m}}) & p);
  endfunction : exp_rd

  // watchdog at 20000 cycles, far beyond the roughly 740 cycles the run needs
  initial
  begin
    #(100 * 20000);
    errors++;
    stop_test();
  end

  initial
  begin
    seed = $urandom(5);
    idle(20);
    srst_i <= 1'b0;
    idle(2);
    rd(OFF_A_DIR, 1'b0, 8'h00, "dir a");
    rd(OFF_B_DIR, 1'b0, 8'h00, "dir b");
    cmp("oe a", 8'h00, pa_oe_o);
    wr(OFF_LCD_PIN_EN, 8'h01);
    // random port traffic, all-output and all-input first
    for (int n = 0; n < 24; n++)
    begin
      la = 8'($urandom());
      lb = 8'($urandom());
      da = (n == 0) ? 8'hFF : (n == 1) ? 8'h00 : 8'($urandom());
      db = (n == 0) ? 8'hFF : (n == 1) ? 8'h00 : 8'($urandom());
      ext_a <= 8'($urandom());
      ext_b <= 5'($urandom());
      wr(OFF_A_DATA, la);
      wr(OFF_A_DIR, da);
      wr(OFF_B_DATA, lb);
      wr(OFF_B_DIR, db);
      idle(3);
      cmp("oe a", da, pa_oe_o);
      cmp("out a", la & da, pa_out_o & da);
      cmp("oe b", db & 8'h1F, {3'h0, pb_oe_o});
      cmp("out b", lb & db & 8'h1F, {3'h0, pb_out_o} & db);
      rd(OFF_A_DATA, 1'b0, exp_rd(la, da, ext_a, 1'b0), "rd a");
      rd(OFF_A_DATA, 1'b1, la, "rmw a");
      rd(OFF_B_DATA, 1'b0, exp_rd(lb, db, {3'h0, ext_b}, 1'b0) & 8'h1F, "rd b");
      rd(OFF_B_DATA, 1'b1, lb & 8'h1F, "rmw b");
      rd(OFF_B_DIR, 1'b0, db & 8'h1F, "dir b");
    end
    // reset in mid-run clears the direction bits
    wr(OFF_A_DIR, 8'hFF);
    srst_i <= 1'b1;
    idle(2);
    srst_i <= 1'b0;
    idle(2);
    rd(OFF_A_DIR, 1'b0, 8'h00, "dir a rst");
    cmp("oe a rst", 8'h00, pa_oe_o);
    // lcd takes its selected pins, direction cleared there
    sa = 8'($urandom());
    sb = 8'($urandom());
    la = 8'($urandom());
    lb = 8'($urandom());
    da = 8'($urandom()) & ~sa;
    db = 8'($urandom()) & ~sb & 8'h1F;
    wr(OFF_A_DATA, la);
    wr(OFF_A_DIR, da);
    wr(OFF_B_DATA, lb);
    wr(OFF_B_DIR, db);
    wr(OFF_LCD_COM_SEL, sa);
    wr(OFF_LCD_SEG_LOW, sb);
    wr(OFF_LCD_SEG_HIGH, sb >> 2);
    lcd_com_i <= 8'($urandom());
    lcd_seg_low_i <= 2'($urandom());
    lcd_seg_high_i <= 3'($urandom());
    wr(OFF_LCD_PIN_EN, 8'h01);
    idle(3);
    cmp("lcd oe a", sa | da, pa_oe_o);
    cmp("lcd out a", (sa & lcd_com_i) | (da & la), pa_out_o & pa_oe_o);
    cmp("lcd oe b", (sb | db) & 8'h1F, {3'h0, pb_oe_o});
    cmp("lcd out b", ((sb & {3'h0, lcd_seg_high_i, lcd_seg_low_i}) | (db & lb)) & 8'h1F,
      {3'h0, pb_out_o & pb_oe_o});
    rd(OFF_LCD_COM_SEL, 1'b0, sa, "com sel");
    rd(OFF_LCD_SEG_LOW, 1'b0, sb & 8'h03, "seg low");
    rd(OFF_LCD_SEG_HIGH, 1'b0, (sb >> 2) & 8'h07, "seg high");
    rd(OFF_LCD_PIN_EN, 1'b0, 8'h01, "input control");
    // without input control the port drives only by direction
    wr(OFF_LCD_PIN_EN, 8'h00);
    idle(3);
    cmp("oe a gated", da, pa_oe_o);
    rd(OFF_A_DATA, 1'b0, da & la, "rd a gated");
    wr(OFF_LCD_PIN_EN, 8'h01);
    wr(OFF_STANDBY_CTL, 8'h00);
    stop_mode_i <= 1'b1;
    idle(3);
    cmp("keep oe a", sa | da, pa_oe_o);
    cmp("keep out a", (sa & lcd_com_i) | (da & la), pa_out_o & pa_oe_o);
    // float in stop, then in watch
    for (int m = 0; m < 2; m++)
    begin
      wr(OFF_STANDBY_CTL, 8'h01);
      stop_mode_i <= (m == 0);
      watch_mode_i <= (m == 1);
      idle(4);
      cmp("float oe a", 8'h00, pa_oe_o);
      cmp("float oe b", 8'h00, {3'h0, pb_oe_o});
      rd(OFF_A_DATA, 1'b0, da & la, "float rd a");
      rd(OFF_STANDBY_CTL, 1'b0, 8'h01, "float bit");
      stop_mode_i <= 1'b0;
      watch_mode_i <= 1'b0;
    end
    // unmapped place reads zero and disturbs nothing
    wr(8'h20, 8'hA5);
    rd(8'h20, 1'b0, 8'h00, "unmapped");
    rd(OFF_A_DATA, 1'b1, la, "latch kept");
    stop_test();
  end
endmodule : lcd_gpio_ports_test
